//--- rtl/adc_defs.svh
// Constants for the converter control block: offsets, fields, reset values and timing
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------------------------------------
// Register selector codes (top two bits of a written byte)
// ----------------------------------------------------------------------
`define SEL_CONV_CTRL 2'h0
`define SEL_FORMAT 2'h1

// ----------------------------------------------------------------------
// Field positions inside the six control bits
// ----------------------------------------------------------------------
`define CC_TRIG_SRC 5
`define CC_STYLE 4
`define CC_CLK_SRC 3
`define CC_PWRDN 2
`define FC_OSC_SPEED 4
`define FC_CODING 1

// ----------------------------------------------------------------------
// Reset and default values
// ----------------------------------------------------------------------
`define CTRL_RESET 6'h00
`define RESULT_RESET 8'h00
`define SAR_FIRST_TRIAL 8'h80

// ----------------------------------------------------------------------
// Timing: system clock, oscillator rates and cycle counts
// ----------------------------------------------------------------------
`define CLK_MHZ 100
`define OSC_SLOW_MHZ 10
`define OSC_FAST_MHZ 20
`define DIV_SLOW_CYC (`CLK_MHZ / `OSC_SLOW_MHZ)
`define DIV_FAST_CYC (`CLK_MHZ / `OSC_FAST_MHZ)
`define SW_SAMPLE_TICKS 6
`define CONVERT_TICKS 10
`define RESULT_BITS 8
`define PULSE_CYC 2

`endif

//--- rtl/adc_pkg.sv
// Types shared by the converter control block
package adc_pkg;

  // Sequencer states, Gray coded along idle, sample, convert, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3,
    ST_DONE = 2'h2
  } conv_state_e;

  // Conversion control register layout
  typedef struct packed {
    logic trigger_source_select;
    logic completion_style_select;
    logic clock_source_select;
    logic soft_powerdown;
    logic [1:0] ignored;
  } conv_ctrl_s;

  // Format register layout
  typedef struct packed {
    logic rsv5;
    logic oscillator_speed;
    logic rsv3;
    logic rsv2;
    logic output_coding;
    logic rsv0;
  } format_ctrl_s;

  // Host-side strobe and clock pins
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic hw_trigger_n;
    logic converter_clock;
  } host_pins_s;

endpackage : adc_pkg

//--- rtl/sar_adc_config_and_trigger.sv
// Configuration registers, trigger sequencing and SAR control of an 8-bit converter
`timescale 1ns/1ps
`include "adc_defs.svh"

// Overview of operation
// - Software-mode sample plus convert takes sixteen converter clocks
// - Top two bits select target control register
// - Each write replaces all six bits
// - Control bit 5 picks hardware or software start
// - Control bit 4 picks pulse or level completion
// - Control bit 3 picks internal or external clock
// - Control bit 2 enters software power-down
// - Control bits 1 and 0 are ignored
// - Format bit 4 picks slow or fast oscillator
// - Format bit 1 picks binary or two's complement
// - Read strobe with write low zeroes both registers
// - All-zero default gives slow oscillator, hardware start
// - Hardware strobe falling samples, rising starts conversion
// - Pulse mode gives one pulse per conversion
// - Level mode: low during conversion, high after
// - Software start: write rise first, then read rise
// - Software mode converts six clocks after sampling starts
// - Configuration captured on write rise with select low
// - Read cycle starts on read fall with select low
// - Clock source changes at the programming write
module sar_adc_config_and_trigger
  import adc_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Host strobes and external converter clock pin
  input wire host_pins_s pins,
  // Parallel data bus, split into in, out and enable
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe_n,
  // Completion pin, pulse or level
  output logic done_n,
  // Analog front end
  input wire logic comp_hi,
  output logic [7:0] dac_code,
  output logic sampling,
  output logic powerdown
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Rising edge between two samples
  function automatic logic rose_f(input logic now_v, input logic prev_v);
    rose_f = now_v & ~prev_v;
  endfunction : rose_f

  // Result coding: flip the sign bit for two's complement
  function automatic logic [7:0] code_f(input logic [7:0] raw, input logic twos);
    code_f = {raw[7] ^ twos, raw[6:0]};
  endfunction : code_f

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  host_pins_s pin_s1_q; // First stage, read only by second
  host_pins_s pin_s2_q; // Synchronised pins
  host_pins_s pin_s3_q; // Delayed copy for edges
  logic [7:0] bus_s1_q; // First stage of bus data
  logic [7:0] bus_s2_q; // Synchronised bus data

  // Two flops on every pin, a third for edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
    end else if (ce) begin
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      bus_s1_q <= bus_in;
      bus_s2_q <= bus_s1_q;
    end
  end

  // Edge events on the synchronised pins
  logic wr_rise, rd_rise, rd_fall, trig_rise, trig_fall, ext_rise;
  logic sel_low; // Chip select active
  assign wr_rise = rose_f(pin_s2_q.wr_n, pin_s3_q.wr_n);
  assign rd_rise = rose_f(pin_s2_q.rd_n, pin_s3_q.rd_n);
  assign rd_fall = rose_f(pin_s3_q.rd_n, pin_s2_q.rd_n);
  assign trig_rise = rose_f(pin_s2_q.hw_trigger_n, pin_s3_q.hw_trigger_n);
  assign trig_fall = rose_f(pin_s3_q.hw_trigger_n, pin_s2_q.hw_trigger_n);
  assign ext_rise = rose_f(pin_s2_q.converter_clock, pin_s3_q.converter_clock);
  assign sel_low = ~pin_s2_q.cs_n;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  conv_ctrl_s ctl_q, ctl_d; // Conversion control
  format_ctrl_s fmt_q, fmt_d; // Format control
  logic cfg_write; // Valid write strobe
  logic dflt_load; // Dummy read with write held low

  assign cfg_write = wr_rise & sel_low;
  assign dflt_load = rd_rise & ~pin_s2_q.wr_n;

  // Next register values from a write
  always_comb begin
    ctl_d = ctl_q;
    fmt_d = fmt_q;
    if (dflt_load) begin
      // Hardware configuration loads zeros
      ctl_d = conv_ctrl_s'(`CTRL_RESET);
      fmt_d = format_ctrl_s'(`CTRL_RESET);
    end else if (cfg_write) begin
      // Whole six-bit value replaces the addressed register
      unique case (bus_s2_q[7:6])
        `SEL_CONV_CTRL: ctl_d = conv_ctrl_s'(bus_s2_q[5:0]);
        `SEL_FORMAT: fmt_d = format_ctrl_s'(bus_s2_q[5:0]);
        default: begin
          // Unused selectors leave both registers alone
          ctl_d = ctl_q;
          fmt_d = fmt_q;
        end
      endcase
    end
  end

  // Register storage; bits 1:0 of control are stored but never read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_q <= conv_ctrl_s'(`CTRL_RESET);
      fmt_q <= format_ctrl_s'(`CTRL_RESET);
    end else if (ce) begin
      ctl_q <= ctl_d;
      fmt_q <= fmt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Converter clock: internal oscillator divider or external pin
  // ----------------------------------------------------------------------
  conv_state_e state_q; // Sequencer state
  logic [3:0] div_q; // Oscillator divider
  logic [3:0] div_last; // Divider terminal count
  logic osc_tick; // Internal oscillator period
  logic conv_tick; // One converter clock period
  logic osc_run; // Oscillator runs only while busy

  assign div_last = fmt_q.oscillator_speed ? 4'(`DIV_FAST_CYC - 1) : 4'(`DIV_SLOW_CYC - 1);
  assign osc_run = (state_q == ST_SAMPLE) || (state_q == ST_CONVERT);
  assign osc_tick = osc_run && (div_q == div_last);
  assign conv_tick = ctl_q.clock_source_select ? ext_rise : osc_tick;

  // Internal clock starts with each trigger and stops after conversion
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= 4'h0;
    end else if (ce) begin
      if (!osc_run || osc_tick) begin
        div_q <= 4'h0;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------------
  logic sw_start; // Software sampling start
  logic start; // Sampling start for current mode

  // First start from the write, later ones from reads
  assign sw_start = ctl_d.trigger_source_select && (cfg_write || (rd_rise && sel_low));
  assign start = ctl_d.trigger_source_select ? sw_start : trig_fall;

  // ----------------------------------------------------------------------
  // SAR trial update
  // ----------------------------------------------------------------------
  logic [7:0] sar_q, sar_d; // Successive approximation register
  logic [3:0] cnt_q; // Converter clocks within a phase
  logic [2:0] bit_idx; // Bit under trial

  assign bit_idx = 3'(4'(`RESULT_BITS - 1) - cnt_q);

  // Keep or drop the trial bit, then try the next one
  always_comb begin
    sar_d = sar_q;
    if (cnt_q < 4'(`RESULT_BITS)) begin
      if (!comp_hi) begin
        sar_d[bit_idx] = 1'b0;
      end
      if (bit_idx != 3'h0) begin
        sar_d[bit_idx - 3'h1] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic [7:0] result_q; // Latest finished result
  logic [1:0] pulse_q; // Completion pulse length

  // Sampling, conversion and completion signalling
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sar_q <= 8'h00;
      result_q <= `RESULT_RESET;
      done_n <= 1'b1;
      pulse_q <= 2'h0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          // Power-down ignores every trigger
          if (start && !ctl_d.soft_powerdown) begin
            state_q <= ST_SAMPLE;
            cnt_q <= 4'h0;
          end
        end
        ST_SAMPLE: begin
          if (!ctl_q.trigger_source_select) begin
            // Hardware mode samples until the strobe rises
            if (trig_rise) begin
              state_q <= ST_CONVERT;
              cnt_q <= 4'h0;
              sar_q <= `SAR_FIRST_TRIAL;
              done_n <= ~ctl_q.completion_style_select;
            end
          end else if (conv_tick) begin
            // Software mode samples a fixed number of clocks
            if (cnt_q == 4'(`SW_SAMPLE_TICKS - 1)) begin
              state_q <= ST_CONVERT;
              cnt_q <= 4'h0;
              sar_q <= `SAR_FIRST_TRIAL;
              done_n <= ~ctl_q.completion_style_select;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (conv_tick) begin
            sar_q <= sar_d;
            if (cnt_q == 4'(`CONVERT_TICKS - 1)) begin
              // End of conversion: level rises, or pulse begins
              state_q <= ST_DONE;
              result_q <= sar_q;
              done_n <= ctl_q.completion_style_select;
              pulse_q <= 2'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_DONE: begin
          // Hold the pulse its fixed length, then release
          if (!ctl_q.completion_style_select && pulse_q != 2'(`PULSE_CYC - 1)) begin
            pulse_q <= pulse_q + 2'h1;
          end else begin
            state_q <= ST_IDLE;
            done_n <= 1'b1;
          end
        end
      endcase
    end
  end

  // Front-end outputs straight from the SAR register, state and control register
  assign dac_code = sar_q;
  assign sampling = (state_q == ST_SAMPLE);
  assign powerdown = ctl_q.soft_powerdown;

  // ----------------------------------------------------------------------
  // Read cycle
  // ----------------------------------------------------------------------

  // Drive coded result from read fall until read rise or deselect
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_out <= 8'h00;
      bus_oe_n <= 1'b1;
    end else if (ce) begin
      if (rd_fall && sel_low) begin
        bus_out <= code_f(result_q, fmt_q.output_coding);
        bus_oe_n <= 1'b0;
      end else if (rd_rise || !sel_low) begin
        bus_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !ce);

  logic [4:0] busy_cnt_q; // Clocks from conversion start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_cnt_q <= 5'h00;
    end else if (ce) begin
      if (state_q != ST_CONVERT) begin
        busy_cnt_q <= 5'h00;
      end else if (conv_tick) begin
        busy_cnt_q <= busy_cnt_q + 5'h01;
      end
    end
  end

  chk_conv_write: assert property (
    cfg_write && !dflt_load && bus_s2_q[7:6] == 2'h0 |=> ctl_q == $past(bus_s2_q[5:0]))
    else $error("control register not loaded from write");

  chk_bad_selector: assert property (
    cfg_write && bus_s2_q[7] |=> $stable(ctl_q) && $stable(fmt_q))
    else $error("unused selector changed a register");

  chk_default_load: assert property (
    dflt_load |=> ctl_q == 6'h00 && fmt_q == 6'h00)
    else $error("dummy read did not clear registers");

  chk_sw_sample_len: assert property (
    state_q == ST_SAMPLE && ctl_q.trigger_source_select && conv_tick && cnt_q == 4'h5
    |=> state_q == ST_CONVERT)
    else $error("software sampling not six clocks");

  chk_convert_len: assert property (
    state_q == ST_CONVERT |-> busy_cnt_q <= 5'h0a)
    else $error("conversion ran past ten clocks");

  chk_hw_trigger: assert property (
    state_q == ST_IDLE && trig_fall && !ctl_d.trigger_source_select && !ctl_d.soft_powerdown
    |=> state_q == ST_SAMPLE)
    else $error("hardware strobe did not start sampling");

  chk_level_low: assert property (
    state_q == ST_CONVERT && ctl_q.completion_style_select && $stable(ctl_q) |-> !done_n)
    else $error("level output not low during conversion");

  chk_pulse_shape: assert property (
    $fell(done_n) && !ctl_q.completion_style_select && state_q == ST_DONE
    |-> !done_n ##1 !done_n ##1 done_n)
    else $error("completion pulse wrong length");

  chk_powerdown_hold: assert property (
    state_q == ST_IDLE && ctl_d.soft_powerdown |=> state_q == ST_IDLE)
    else $error("trigger accepted in power-down");

  chk_read_drive: assert property (
    rd_fall && sel_low |=> !bus_oe_n && bus_out == code_f($past(result_q), $past(fmt_q.output_coding)))
    else $error("read did not drive coded result");

  cov_hw_conv: cover property (state_q == ST_CONVERT && !ctl_q.trigger_source_select ##[1:300] state_q == ST_DONE);
  cov_sw_conv: cover property (state_q == ST_CONVERT && ctl_q.trigger_source_select ##[1:300] state_q == ST_DONE);
  cov_default: cover property (dflt_load);
  cov_read: cover property (rd_fall && sel_low);

endmodule : sar_adc_config_and_trigger

//--- tb/host_model.sv
// Host processor model: strobes, data bus and external converter clock
`timescale 1ns/1ps
module host_model
  import adc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins toward the converter
  output host_pins_s pins,
  output logic [7:0] bus_in,
  // Device side of the shared bus
  input wire logic [7:0] bus_out,
  input wire logic bus_oe_n
);
  logic [7:0] host_q; // Value the host puts on the bus
  logic ext_run; // External clock runs only inside a frame
  logic [1:0] ph_q; // External clock divider phase

  // Idle pins at time zero
  initial begin
    pins = 5'h1e;
    host_q = 8'h00;
    ext_run = 1'b0;
    ph_q = 2'h0;
  end

  // Wire level: device wins while it drives
  assign bus_in = bus_oe_n ? host_q : bus_out;

  // External clock, eight system clocks a period, still between frames
  always @(posedge clk) begin
    if (ext_run) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) pins.converter_clock <= ~pins.converter_clock;
    end
  end

  // Configuration write, selector in the top two bits
  task wr(input logic [7:0] d, input logic cs_n);
    @(posedge clk);
    pins.cs_n <= cs_n;
    host_q <= d;
    pins.wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    pins.wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    host_q <= ~d; // Released line shows no stale value
    repeat (2) @(posedge clk);
  endtask : wr

  // Read cycle, result sampled while the strobe is low
  task rd(input logic cs_n, output logic [7:0] d, output logic oe_n);
    @(posedge clk);
    pins.cs_n <= cs_n;
    pins.rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    d = bus_out;
    oe_n = bus_oe_n;
    @(posedge clk);
    pins.rd_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : rd

  // Dummy read with the write strobe held low
  task clr;
    @(posedge clk);
    pins.cs_n <= 1'b1;
    pins.wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    pins.rd_n <= 1'b0;
    repeat (4) @(posedge clk);
    pins.rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    pins.wr_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : clr

  // Hardware start strobe level
  task strobe(input logic v);
    @(posedge clk);
    pins.hw_trigger_n <= v;
  endtask : strobe
endmodule : host_model

//--- tb/sar_adc_config_and_trigger_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_defs.svh"
module sar_adc_config_and_trigger_tb_top;
  import adc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk;
  logic resetn;
  logic ce; // High except during the freeze scenario
  logic [7:0] vin; // Analog level seen by the comparator
  logic comp_hi;
  host_pins_s pins;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic [7:0] dac_code;
  logic bus_oe_n;
  logic done_n;
  logic sampling;
  logic powerdown;
  int n_errors = 0;
  int tests_run = 0;
  int samp_cnt = 0; // Cycles with sampling high
  int done_cnt = 0; // Cycles with completion low
  localparam int FAST = `SW_SAMPLE_TICKS * `DIV_FAST_CYC;
  localparam int SLOW = `SW_SAMPLE_TICKS * `DIV_SLOW_CYC;

  sar_adc_config_and_trigger sar_adc_config_and_trigger_i (.clk(clk), .resetn(resetn), .ce(ce), .pins(pins),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .done_n(done_n), .comp_hi(comp_hi),
    .dac_code(dac_code), .sampling(sampling), .powerdown(powerdown));
  host_model host_model_i (.clk(clk), .pins(pins), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n));

  // Ideal comparator: keep the trial bit while input is not below it
  assign comp_hi = (vin >= dac_code);

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free-running duration counters
  always @(posedge clk) begin
    if (sampling === 1'b1) samp_cnt <= samp_cnt + 1;
    if (done_n === 1'b0) done_cnt <= done_cnt + 1;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // Cycle count inside a window
  task rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      n_errors++;
    end
  endtask : rng

  // Wait for sampling (s=0) or completion (s=1) to reach v, bounded
  task wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((((s == 0) ? sampling : done_n) !== v) && n < lim);
  endtask : wait_for

  // Whole completion indication seen
  task conv_done;
    int n;
    wait_for(1, 1'b0, 400, n);
    rng(n, 1, 399);
    wait_for(1, 1'b1, 200, n);
    rng(n, 1, 199);
  endtask : conv_done

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_sw(input logic [7:0] fmt, input int exp_s);
    int s0;
    int d0;
    host_model_i.wr(8'h00, 1'b0);
    host_model_i.wr(fmt, 1'b0);
    s0 = samp_cnt;
    d0 = done_cnt;
    host_model_i.wr(8'h20, 1'b0);
    conv_done();
    rng(samp_cnt - s0, exp_s - 1, exp_s + 1);
    chk(8'(done_cnt - d0), 8'(`PULSE_CYC));
  endtask : t_sw

  task t_read;
    logic [7:0] d;
    logic oe;
    int s0;
    s0 = samp_cnt;
    host_model_i.rd(1'b0, d, oe);
    chk({7'h00, oe}, 8'h00);
    chk(d, 8'ha5);
    conv_done();
    rng(samp_cnt - s0, FAST - 1, FAST + 1);
    host_model_i.wr(8'h00, 1'b0);
    host_model_i.wr(8'h52, 1'b0);
    host_model_i.rd(1'b0, d, oe);
    chk(d, 8'h25);
    host_model_i.rd(1'b1, d, oe);
    chk({7'h00, oe}, 8'h01);
  endtask : t_read

  task t_level;
    int s0;
    int d0;
    int n;
    s0 = samp_cnt;
    d0 = done_cnt;
    host_model_i.wr(8'h30, 1'b0);
    wait_for(1, 1'b0, 200, n);
    chk({7'h00, sampling}, 8'h00);
    wait_for(1, 1'b1, 200, n);
    rng(done_cnt - d0, 49, 51);
    rng(samp_cnt - s0 + done_cnt - d0, 79, 81);
  endtask : t_level

  task t_hw;
    int d0;
    int n;
    host_model_i.wr(8'h00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      host_model_i.strobe(1'b0);
      wait_for(0, 1'b1, 10, n);
      rng(n, 1, 9);
      repeat (20) @(posedge clk);
      chk({7'h00, sampling}, 8'h01);
      d0 = done_cnt;
      host_model_i.strobe(1'b1);
      conv_done();
      chk(8'(done_cnt - d0), 8'(`PULSE_CYC));
    end
  endtask : t_hw

  task t_ignore;
    logic [7:0] dv [3] = '{8'ha0, 8'he0, 8'h20};
    logic [7:0] d;
    logic oe;
    int n;
    for (int i = 0; i < 3; i++) begin
      host_model_i.wr(dv[i], i == 2);
      wait_for(0, 1'b1, 12, n);
      rng(n, 12, 12);
    end
    host_model_i.rd(1'b0, d, oe);
    chk(d, 8'h25);
  endtask : t_ignore

  task t_pwr;
    logic [7:0] d;
    logic oe;
    int n;
    host_model_i.wr(8'h07, 1'b0);
    chk({7'h00, powerdown}, 8'h01);
    host_model_i.strobe(1'b0);
    wait_for(0, 1'b1, 12, n);
    rng(n, 12, 12);
    host_model_i.strobe(1'b1);
    host_model_i.clr();
    chk({7'h00, powerdown}, 8'h00);
    host_model_i.rd(1'b0, d, oe);
    chk(d, 8'ha5);
    host_model_i.strobe(1'b0);
    wait_for(0, 1'b1, 10, n);
    rng(n, 1, 9);
    host_model_i.strobe(1'b1);
    wait_for(1, 1'b0, 400, n);
    rng(n, 95, 110);
    wait_for(1, 1'b1, 200, n);
  endtask : t_pwr

  task t_ext;
    int s0;
    @(posedge clk);
    host_model_i.ext_run <= 1'b1;
    host_model_i.wr(8'h50, 1'b0);
    s0 = samp_cnt;
    host_model_i.wr(8'h28, 1'b0);
    conv_done();
    rng(samp_cnt - s0, 44, 52);
    host_model_i.ext_run <= 1'b0;
  endtask : t_ext

  // Freeze mid-sampling, new input level, then a second reset
  task t_freeze;
    logic [7:0] d;
    logic oe;
    vin <= 8'h3c;
    host_model_i.wr(8'h20, 1'b0);
    repeat (2) @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    chk({7'h00, sampling}, 8'h01);
    ce <= 1'b1;
    conv_done();
    host_model_i.rd(1'b0, d, oe);
    chk(d, 8'h3c);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    chk({bus_oe_n, done_n, sampling, powerdown}, 8'h0c);
    resetn <= 1'b1;
    host_model_i.rd(1'b0, d, oe);
    chk(d, 8'h00);
  endtask : t_freeze

  // Verdict and end of run
  task stop_test;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    vin = 8'ha5;
    repeat (5) @(posedge clk);
    #1;
    chk({bus_oe_n, done_n, sampling, powerdown}, 8'h0c);
    chk(dac_code, 8'h00);
    @(posedge clk);
    resetn <= 1'b1;
    t_sw(8'h40, SLOW);
    t_sw(8'h50, FAST);
    t_read();
    t_level();
    t_hw();
    t_ignore();
    t_pwr();
    t_ext();
    t_freeze();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : sar_adc_config_and_trigger_tb_top
